// file: bench/dpm_ctrl_props.sv
// Concurrent checks on the ports of the protection and mode controller.
`timescale 1ns/1ns
module dpm_ctrl_chk
  import dpm_pkg::*;
#(
  parameter int NUM_CH = DPM_NUM_CH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic override_n,
  input wire logic shutdown_n,
  input wire logic trip_clear_input,
  input wire logic [NUM_CH-1:0] ch_overload,
  input wire logic [NUM_CH-1:0] ch_short,
  input wire dpm_unit_err_s unit_err,
  input wire logic [NUM_CH-1:0] ch_enable,
  input wire logic unit_error_indicator_n_o,
  input wire logic unit_error_indicator_n_oe,
  input wire logic spare_indicator_n_o
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_quiet;
    ch_short == '0 && ch_overload == '0 && unit_err == '0;
  endsequence
  sequence s_clear_fall;
    $fell(trip_clear_input) ##0 s_quiet ##1 s_quiet [*3];
  endsequence
  chk_fault_drain: assert property (unit_error_indicator_n_o == 1'b0)
    else $error("fault pin driven high");
  chk_spare_drain: assert property (spare_indicator_n_o == 1'b0)
    else $error("spare pin driven high");
  chk_shdn_off: assert property (!shutdown_n [*3] |-> ch_enable == '0)
    else $error("channel on during shutdown");
  chk_short_off: assert property (ch_short != '0 |-> ##2 (ch_enable & $past(ch_short, 2)) == '0)
    else $error("shorted channel left on");
  chk_short_flag: assert property (ch_short != '0 |-> ##[1:3] unit_error_indicator_n_oe)
    else $error("short not flagged");
  chk_err_flag: assert property (unit_err != '0 && override_n |=> unit_error_indicator_n_oe)
    else $error("unit error not flagged");
  chk_ovr_keep: assert property (!override_n && ch_short == '0 && $past(ch_short) == '0 &&
    $past(ch_short, 2) == '0 && shutdown_n && $past(shutdown_n) |=> ($past(ch_enable) & ~ch_enable) == '0)
    else $error("channel dropped under override");
  chk_clear_oe: assert property (s_clear_fall |=> !unit_error_indicator_n_oe)
    else $error("trip not cleared by pin");
endmodule

// file: bench/dpm_host.sv
// Host and discrete wiring model on the far side of the controller.
`timescale 1ns/1ns
module dpm_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [1:0] mode_sel_n,
  output logic override_n,
  output logic shutdown_n,
  output logic trip_clear_input
);
  logic [31:0] rd_val;
  event rd_ev;
  // Open discrete inputs rest at the pulled-up level.
  initial begin
    {mode_sel_n, override_n, shutdown_n, trip_clear_input} = 5'h1f;
    {hsel, htrans, hwrite} = 4'h0;
    haddr = 32'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
    hwdata <= ~d;
    if (!w) -> rd_ev;
  endtask
endmodule

// file: bench/test_dpm_ctrl.sv
// Self-checking bench for the protection and mode controller.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module test_dpm_ctrl;
  import dpm_pkg::*;
  localparam int NUM_CH = 14;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, override_n, shutdown_n, trip_clear_input;
  logic [31:0] haddr, hwdata, hrdata, exp_v;
  logic [1:0] htrans, mode_sel_n;
  logic [2:0] hsize;
  logic [13:0] ch_overload = '0;
  logic [13:0] ch_short = '0;
  logic [13:0] ch_enable;
  logic unit_error_indicator_n_o, unit_error_indicator_n_oe, spare_indicator_n_o, spare_indicator_n_oe;
  dpm_unit_err_s unit_err = '0;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];
  assign hready = hreadyout;
  dpm_ctrl #(.STEP_CYCLES(8)) uut (.*);
  dpm_host host (.*);
  always #4 hclk = ~hclk;
  always @(host.rd_ev) begin
    exp_v = exp_q.pop_front();
    `CHK(host.rd_val, exp_v)
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic rst;
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(6);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #80000;
    err_total++;
    report_and_stop();
  end
  initial begin
    logic [13:0] m;
    logic [31:0] v;
    void'($urandom(77));
    cyc(20);
    `CHK({ch_enable, unit_error_indicator_n_oe, spare_indicator_n_oe}, 16'h0)
    hresetn <= 1'b1;
    wr(DPM_CTRL, 32'h0);
    wr(DPM_BOOT, 32'h0);
    for (int i = 0; i < 14; i++) begin
      v = $urandom & 32'hff;
      wr(DPM_I2T_BASE + 12'(4 * i), v);
      rd(DPM_I2T_BASE + 12'(4 * i), v);
      wr(DPM_ITRIP_BASE + 12'(4 * i), v ^ 32'h5a5a);
      rd(DPM_ITRIP_BASE + 12'(4 * i), v ^ 32'h5a5a);
    end
    for (int g = 0; g < 7; g++) wr(DPM_GROUP_BASE + 12'(4 * g), 32'h0);
    for (int k = 0; k < 3; k++) wr(DPM_MSEL_BASE + 12'(4 * k), 32'(3 >> k));
    wr(DPM_MDIR_BASE, 32'h3);
    wr(DPM_MDIR_BASE + 12'h4, 32'h0);
    wr(DPM_DELAY_BASE, 32'h0);
    wr(DPM_DELAY_BASE + 12'h4, 32'h2);
    wr(DPM_DELAY_BASE + DPM_DELAY_STRIDE, 32'h1);
    v = $urandom & 32'hff;
    wr(DPM_LIM_V, v);
    rst();
    rd(DPM_LIM_V, v);
    rd(DPM_GROUP_BASE + 12'h1c, 32'h0);
    wr(DPM_GROUP_BASE, 32'h3000);
    rd(DPM_GROUP_BASE, 32'h3000);
    `CHK({hreadyout, hresp}, 2'b10)
    m = (14'($urandom) | 14'h1001) & 14'h1fff;
    wr(DPM_CH_ON, 32'(m));
    cyc(3);
    `CHK(ch_enable, m | 14'h3000)
    rd(DPM_CH_STATE, 32'(m | 14'h3000));
    wr(DPM_CH_OFF, 32'h2000);
    cyc(3);
    `CHK(ch_enable, m & 14'h0fff)
    ch_short <= 14'h1;
    cyc(1);
    ch_short <= '0;
    cyc(4);
    `CHK({ch_enable[0], unit_error_indicator_n_oe}, 2'b01)
    rd(DPM_TRIP, 32'h1);
    host.trip_clear_input <= 1'b0;
    cyc(5);
    rd(DPM_TRIP, 32'h0);
    `CHK(unit_error_indicator_n_oe, 1'b0)
    host.trip_clear_input <= 1'b1;
    ch_short <= 14'h2;
    cyc(1);
    ch_short <= '0;
    cyc(4);
    wr(DPM_CTRL, 32'h40);
    cyc(2);
    rd(DPM_TRIP, 32'h0);
    host.override_n <= 1'b0;
    cyc(2);
    ch_overload <= '1;
    unit_err <= 4'hf;
    cyc(4);
    `CHK({ch_enable, unit_error_indicator_n_oe}, {m & 14'h0ffc, 1'b0})
    rd(DPM_UNIT, 32'h10);
    ch_overload <= '0;
    unit_err <= '0;
    cyc(2);
    host.override_n <= 1'b1;
    cyc(2);
    unit_err <= 4'h4;
    cyc(3);
    `CHK(unit_error_indicator_n_oe, 1'b1)
    unit_err <= '0;
    cyc(3);
    `CHK(unit_error_indicator_n_oe, 1'b0)
    wr(DPM_CTRL, 32'h81);
    rd(DPM_UNIT, 32'h10);
    `CHK(spare_indicator_n_oe, 1'b1)
    wr(DPM_CTRL, 32'h0);
    wr(DPM_CH_ON, 32'h3);
    host.shutdown_n <= 1'b0;
    cyc(3);
    `CHK(ch_enable, 14'h0)
    wr(DPM_CH_ON, 32'h3);
    cyc(3);
    `CHK(ch_enable, 14'h0)
    rd(DPM_UNIT, 32'h20);
    host.shutdown_n <= 1'b1;
    wr(DPM_CH_ON, 32'h3);
    wr(DPM_CTRL, 32'h2);
    cyc(3);
    `CHK(ch_enable, 14'h0)
    wr(DPM_CTRL, 32'h0);
    host.mode_sel_n <= 2'b10;
    cyc(6);
    `CHK(ch_enable, 14'h1)
    cyc(11);
    `CHK(ch_enable, 14'h1)
    cyc(8);
    `CHK(ch_enable, 14'h3)
    host.mode_sel_n <= 2'b11;
    cyc(2100);
    wr(DPM_CTRL, 32'h28);
    cyc(3);
    `CHK(ch_enable, 14'h3)
    cyc(14);
    `CHK(ch_enable, 14'h2)
    wr(DPM_BOOT, 32'h1);
    wr(DPM_CTRL, 32'h24);
    rst();
    `CHK(ch_enable, 14'h1)
    rd(DPM_BOOT, 32'h1);
    wr(DPM_CTRL, 32'h0);
    rst();
    `CHK(ch_enable, 14'h0)
    report_and_stop();
  end
endmodule
bind dpm_ctrl dpm_ctrl_chk #(.NUM_CH(NUM_CH)) chk (.*);

// file: design/dpm_ctrl.sv
// Supervisory channel, mode and protection controller with an AHB-Lite register slave.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module dpm_ctrl
  import dpm_pkg::*;
#(
  parameter int NUM_CH = DPM_NUM_CH,
  parameter int NUM_GRP = DPM_NUM_GRP,
  parameter int STEP_CYCLES = DPM_STEP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] mode_sel_n,
  input wire logic override_n,
  input wire logic shutdown_n,
  input wire logic trip_clear_input,
  input wire logic [NUM_CH-1:0] ch_overload,
  input wire logic [NUM_CH-1:0] ch_short,
  input wire dpm_unit_err_s unit_err,
  output logic [NUM_CH-1:0] ch_enable,
  output logic unit_error_indicator_n_o,
  output logic unit_error_indicator_n_oe,
  output logic spare_indicator_n_o,
  output logic spare_indicator_n_oe
);
  // Configuration is kept in unreset storage so that a bus reset never wipes it; the
  // nonvolatile image behind it is loaded by software after power-up.
  logic [NUM_CH-1:0] group_mask [NUM_GRP];
  logic [NUM_CH-1:0] mode_sel_mask [DPM_NUM_MODE];
  logic [NUM_CH-1:0] mode_dir_mask [DPM_NUM_MODE];
  logic [7:0] mode_delay [DPM_NUM_MODE][NUM_CH];
  logic [15:0] i2t_set [NUM_CH];
  logic [15:0] itrip_set [NUM_CH];
  logic [31:0] lim_v_reg;
  logic [31:0] lim_t_reg;
  logic boot_en_reg;
  logic [1:0] boot_mode_reg;

  logic sw_ovr_reg;
  logic sw_shdn_reg;
  logic [1:0] sw_mode_reg;
  logic spare_reg;
  logic go_reg;
  logic clr_reg;
  logic [NUM_CH-1:0] on_req_reg;
  logic [NUM_CH-1:0] off_req_reg;
  dpm_bus_req_s req_reg;
  logic [NUM_CH-1:0] ch_reg;
  logic [NUM_CH-1:0] ch_next;
  logic [NUM_CH-1:0] trip_reg;
  logic trip_pin_prev_reg;
  logic boot_pend_reg;
  dpm_seq_e seq_reg;
  logic [1:0] run_mode_reg;
  logic [1:0] mode_prev_reg;
  logic [7:0] step_reg;
  logic [31:0] tick_reg;

  logic ovr_act;
  logic shdn_act;
  logic [1:0] hw_mode;
  logic [1:0] cur_mode;
  logic start_mode;
  logic [1:0] start_sel;
  logic step_edge;
  logic [NUM_CH-1:0] trip_new;
  logic [NUM_CH-1:0] mode_on;
  logic [NUM_CH-1:0] mode_off;
  logic clr_trip;
  logic unit_fault;
  logic addr_ok;
  logic wr_en;

  // Widens a channel mask to all members of every group it touches.
  function automatic logic [NUM_CH-1:0] grp_expand(input logic [NUM_CH-1:0] m);
    logic [NUM_CH-1:0] r;
    r = m;
    for (int g = 0; g < NUM_GRP; g++) begin
      if ((m & group_mask[g]) != '0) begin
        r = r | group_mask[g];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    logic [31:0] d;
    int idx;
    d = 32'h0000_0000;
    idx = 0;
    if (a == DPM_CTRL) begin
      d[DPM_CTRL_OVR] = sw_ovr_reg;
      d[DPM_CTRL_SHDN] = sw_shdn_reg;
      d[DPM_CTRL_BOOT_EN] = boot_en_reg;
      d[DPM_CTRL_MODE_LO +: 2] = sw_mode_reg;
      d[DPM_CTRL_SPARE] = spare_reg;
    end else if (a == DPM_BOOT) begin
      d[1:0] = boot_mode_reg;
    end else if (a == DPM_CH_STATE) begin
      d[NUM_CH-1:0] = ch_reg;
    end else if (a == DPM_TRIP) begin
      d[NUM_CH-1:0] = trip_reg;
    end else if (a == DPM_UNIT) begin
      d[3:0] = ovr_act ? 4'h0 : unit_err;
      d[4] = ovr_act;
      d[5] = shdn_act;
      d[7:6] = (seq_reg == DPM_RUN) ? run_mode_reg : 2'h0;
      d[15:8] = step_reg;
    end else if (a == DPM_LIM_V) begin
      d = lim_v_reg;
    end else if (a == DPM_LIM_T) begin
      d = lim_t_reg;
    end else if (a >= DPM_GROUP_BASE && a < DPM_MSEL_BASE) begin
      idx = int'(a - DPM_GROUP_BASE) / 4;
      if (idx < NUM_GRP) begin
        d[NUM_CH-1:0] = group_mask[idx];
      end
    end else if (a >= DPM_MSEL_BASE && a < DPM_MDIR_BASE) begin
      idx = int'(a - DPM_MSEL_BASE) / 4;
      if (idx < DPM_NUM_MODE) begin
        d[NUM_CH-1:0] = mode_sel_mask[idx];
      end
    end else if (a >= DPM_MDIR_BASE && a < DPM_I2T_BASE) begin
      idx = int'(a - DPM_MDIR_BASE) / 4;
      if (idx < DPM_NUM_MODE) begin
        d[NUM_CH-1:0] = mode_dir_mask[idx];
      end
    end else if (a >= DPM_I2T_BASE && a < DPM_ITRIP_BASE) begin
      idx = int'(a - DPM_I2T_BASE) / 4;
      if (idx < NUM_CH) begin
        d[15:0] = i2t_set[idx];
      end
    end else if (a >= DPM_ITRIP_BASE && a < DPM_DELAY_BASE) begin
      idx = int'(a - DPM_ITRIP_BASE) / 4;
      if (idx < NUM_CH) begin
        d[15:0] = itrip_set[idx];
      end
    end else if (a >= DPM_DELAY_BASE) begin
      idx = int'(a - DPM_DELAY_BASE) / 4;
      if (idx / 16 < DPM_NUM_MODE && idx % 16 < NUM_CH) begin
        d[7:0] = mode_delay[idx / 16][idx % 16];
      end
    end
    return d;
  endfunction

  // Pin and software sources of override and shutdown are ORed, so either one holds it; a nonzero mode pin selection wins over the software mode.
  assign ovr_act = ~override_n | sw_ovr_reg;
  assign shdn_act = ~shutdown_n | sw_shdn_reg;
  assign hw_mode = ~mode_sel_n;
  assign cur_mode = (hw_mode != 2'h0) ? hw_mode : sw_mode_reg;
  assign clr_trip = (trip_pin_prev_reg & ~trip_clear_input) | clr_reg;
  assign unit_fault = ~ovr_act & (unit_err != 4'h0);
  assign addr_ok = hsel & hready & htrans[1];
  assign wr_en = req_reg.valid & req_reg.write;
  assign step_edge = (seq_reg == DPM_RUN) && (tick_reg == 32'(STEP_CYCLES - 1));

  always_comb begin
    start_mode = 1'b0;
    start_sel = cur_mode;
    if (boot_pend_reg && boot_en_reg && boot_mode_reg != 2'h0) begin
      start_mode = 1'b1;
      start_sel = boot_mode_reg;
    end else if (cur_mode != 2'h0 && (cur_mode != mode_prev_reg || go_reg)) begin
      start_mode = 1'b1;
    end
  end

  // A short always trips; the other trip causes only outside override. This is a process
  // and not a continuous assignment, so that a change of the group table is seen at once.
  always_comb begin
    trip_new = grp_expand(ch_short | (ovr_act ? '0 : ch_overload));
  end

  always_comb begin
    mode_on = '0;
    mode_off = '0;
    if (seq_reg == DPM_RUN && tick_reg == 32'h0) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (mode_sel_mask[run_mode_reg - 2'h1][c] && mode_delay[run_mode_reg - 2'h1][c] == step_reg) begin
          mode_on[c] = mode_dir_mask[run_mode_reg - 2'h1][c];
          mode_off[c] = ~mode_dir_mask[run_mode_reg - 2'h1][c];
        end
      end
    end
    mode_on = grp_expand(mode_on);
    mode_off = grp_expand(mode_off);
  end

  // Shutdown is applied last so that no request of any source can turn a channel on.
  always_comb begin
    ch_next = (ch_reg | on_req_reg | mode_on) & ~(off_req_reg | mode_off);
    ch_next = ch_next & ~(trip_reg | trip_new);
    if (shdn_act) begin
      ch_next = '0;
    end
  end

  // Bus address phase; the slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      req_reg.valid <= addr_ok;
      req_reg.write <= hwrite;
      req_reg.addr <= {haddr[11:2], 2'b00};
      hresp <= DPM_HRESP_OKAY[0];
      hreadyout <= 1'b1;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux({haddr[11:2], 2'b00});
      end
    end
  end

  // Unreset configuration store written in the data phase.
  // It has no reset branch on purpose: a bus reset must leave every setting in place.
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      if (req_reg.addr == DPM_BOOT) begin
        boot_mode_reg <= hwdata[1:0];
      end else if (req_reg.addr == DPM_CTRL) begin
        boot_en_reg <= hwdata[DPM_CTRL_BOOT_EN];
      end else if (req_reg.addr == DPM_LIM_V) begin
        lim_v_reg <= hwdata;
      end else if (req_reg.addr == DPM_LIM_T) begin
        lim_t_reg <= hwdata;
      end
      for (int g = 0; g < NUM_GRP; g++) begin
        if (req_reg.addr == DPM_GROUP_BASE + 12'(4 * g)) begin
          group_mask[g] <= hwdata[NUM_CH-1:0];
        end
      end
      for (int m = 0; m < DPM_NUM_MODE; m++) begin
        if (req_reg.addr == DPM_MSEL_BASE + 12'(4 * m)) begin
          mode_sel_mask[m] <= hwdata[NUM_CH-1:0];
        end
        if (req_reg.addr == DPM_MDIR_BASE + 12'(4 * m)) begin
          mode_dir_mask[m] <= hwdata[NUM_CH-1:0];
        end
        for (int c = 0; c < NUM_CH; c++) begin
          if (req_reg.addr == DPM_DELAY_BASE + 12'(m) * DPM_DELAY_STRIDE + 12'(4 * c)) begin
            mode_delay[m][c] <= hwdata[7:0];
          end
        end
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_reg.addr == DPM_I2T_BASE + 12'(4 * c)) begin
          i2t_set[c] <= hwdata[15:0];
        end
        if (req_reg.addr == DPM_ITRIP_BASE + 12'(4 * c)) begin
          itrip_set[c] <= hwdata[15:0];
        end
      end
    end
  end

  // Control bits and one-cycle commands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_ovr_reg <= 1'b0;
      sw_shdn_reg <= 1'b0;
      sw_mode_reg <= 2'h0;
      spare_reg <= 1'b0;
      go_reg <= 1'b0;
      clr_reg <= 1'b0;
      on_req_reg <= '0;
      off_req_reg <= '0;
    end else begin
      go_reg <= 1'b0;
      clr_reg <= 1'b0;
      on_req_reg <= '0;
      off_req_reg <= '0;
      if (wr_en && req_reg.addr == DPM_CTRL) begin
        sw_ovr_reg <= hwdata[DPM_CTRL_OVR];
        sw_shdn_reg <= hwdata[DPM_CTRL_SHDN];
        sw_mode_reg <= hwdata[DPM_CTRL_MODE_LO +: 2];
        spare_reg <= hwdata[DPM_CTRL_SPARE];
        go_reg <= hwdata[DPM_CTRL_GO];
        clr_reg <= hwdata[DPM_CTRL_CLR];
      end
      if (wr_en && req_reg.addr == DPM_CH_ON) begin
        on_req_reg <= grp_expand(hwdata[NUM_CH-1:0]);
      end
      if (wr_en && req_reg.addr == DPM_CH_OFF) begin
        off_req_reg <= grp_expand(hwdata[NUM_CH-1:0]);
      end
    end
  end

  // Mode sequencer: a step counter advances every 100 ms tick.
  // The run ends after the last step; a new start always restarts it from step zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_reg <= DPM_IDLE;
      run_mode_reg <= 2'h0;
      mode_prev_reg <= 2'h0;
      step_reg <= 8'h00;
      tick_reg <= 32'h0;
      boot_pend_reg <= 1'b1;
    end else begin
      boot_pend_reg <= 1'b0;
      mode_prev_reg <= cur_mode;
      if (start_mode) begin
        seq_reg <= DPM_RUN;
        run_mode_reg <= start_sel;
        step_reg <= 8'h00;
        tick_reg <= 32'h0;
      end else begin
        unique case (seq_reg)
          DPM_IDLE: begin
            tick_reg <= 32'h0;
          end
          DPM_RUN: begin
            if (step_edge) begin
              tick_reg <= 32'h0;
              if (step_reg == DPM_LAST_STEP) begin
                seq_reg <= DPM_IDLE;
              end else begin
                step_reg <= step_reg + 8'h01;
              end
            end else begin
              tick_reg <= tick_reg + 32'h1;
            end
          end
        endcase
      end
    end
  end

  // Trip status: a new trip in the clearing cycle survives the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_reg <= '0;
      trip_pin_prev_reg <= 1'b1;
    end else begin
      trip_pin_prev_reg <= trip_clear_input;
      trip_reg <= (clr_trip ? '0 : trip_reg) | trip_new;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch_reg <= '0;
      ch_enable <= '0;
    end else begin
      ch_reg <= ch_next;
      ch_enable <= ch_next;
    end
  end

  // Open drain: enable high pulls the pin low, the output value stays low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_error_indicator_n_o <= 1'b0;
      unit_error_indicator_n_oe <= 1'b0;
      spare_indicator_n_o <= 1'b0;
      spare_indicator_n_oe <= 1'b0;
    end else begin
      unit_error_indicator_n_oe <= (trip_reg != '0) | unit_fault;
      spare_indicator_n_oe <= spare_reg;
    end
  end
endmodule

// file: design/dpm_pkg.sv
// Constants, register map and carrier types of the discrete protection and mode controller.
// Function
// - Fault indicator: active-low open-drain output.
// - One spare active-low open-drain indicator.
// - Active mode switches selected channels after delays.
// - Mode starts by software or discrete pins.
// - Enabled boot mode starts at power-up.
// - Boot enable independent of selected mode.
// - Override by pin low or software.
// - Override ignores all trips except short.
// - Override suppresses voltage and temperature errors.
// - Trip clear pin falling edge clears trips.
// - Software command also clears all trips.
// - Shutdown turns every output off immediately.
// - Shutdown refuses every turn-on request.
// - Shutdown by pin low or software.
// - User configuration survives any reset.
// - Mode delays counted in 100 ms steps.
// - Each mode stores on or off per channel.
// - At most seven parallel groups.
// - Group members switch and trip together.
// - Per-channel trip settings, unit-wide limits.
// - Mode pins active low, idle high.
package dpm_pkg;
  localparam int DPM_CLK_MHZ = 125;
  localparam int DPM_STEP_MS = 100;
  localparam int DPM_STEP_CYCLES = DPM_STEP_MS * 1000 * DPM_CLK_MHZ;
  localparam int DPM_NUM_CH = 14;
  localparam int DPM_NUM_GRP = 7;
  localparam int DPM_NUM_MODE = 3;
  localparam logic [7:0] DPM_LAST_STEP = 8'hff;

  localparam logic [11:0] DPM_CTRL = 12'h000;
  localparam logic [11:0] DPM_BOOT = 12'h004;
  localparam logic [11:0] DPM_CH_ON = 12'h008;
  localparam logic [11:0] DPM_CH_OFF = 12'h00c;
  localparam logic [11:0] DPM_CH_STATE = 12'h010;
  localparam logic [11:0] DPM_TRIP = 12'h014;
  localparam logic [11:0] DPM_UNIT = 12'h018;
  localparam logic [11:0] DPM_LIM_V = 12'h01c;
  localparam logic [11:0] DPM_LIM_T = 12'h020;
  localparam logic [11:0] DPM_GROUP_BASE = 12'h040;
  localparam logic [11:0] DPM_MSEL_BASE = 12'h060;
  localparam logic [11:0] DPM_MDIR_BASE = 12'h070;
  localparam logic [11:0] DPM_I2T_BASE = 12'h080;
  localparam logic [11:0] DPM_ITRIP_BASE = 12'h0c0;
  localparam logic [11:0] DPM_DELAY_BASE = 12'h100;
  localparam logic [11:0] DPM_DELAY_STRIDE = 12'h040;

  localparam int DPM_CTRL_OVR = 0;
  localparam int DPM_CTRL_SHDN = 1;
  localparam int DPM_CTRL_BOOT_EN = 2;
  localparam int DPM_CTRL_GO = 3;
  localparam int DPM_CTRL_MODE_LO = 4;
  localparam int DPM_CTRL_CLR = 6;
  localparam int DPM_CTRL_SPARE = 7;

  localparam logic [31:0] DPM_HRESP_OKAY = 32'h0000_0000;

  typedef struct packed {
    logic temp_high;
    logic temp_low;
    logic volt_high;
    logic volt_low;
  } dpm_unit_err_s;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } dpm_bus_req_s;

  typedef enum logic [0:0] {DPM_IDLE, DPM_RUN} dpm_seq_e;
endpackage
